// ### logic/ifs_regs.svh
// Constants for the two-wire memory slave: field positions, codes, resets.
`ifndef IFS_REGS_SVH
`define IFS_REGS_SVH

// Memory geometry.
`define IFS_MEM_WORDS      8192
`define IFS_ADDR_W         13
`define IFS_ADDR_RST       13'h0000
`define IFS_ADDR_STEP      13'h0001
`define IFS_BYTE_RST       8'h00
`define IFS_HI_RST         5'h00

// Bit counter marks within one byte slot.
`define IFS_CNT_RST        4'h0
`define IFS_CNT_STEP       4'h1
`define IFS_CNT_FIRST      4'h1
`define IFS_CNT_LAST_BIT   4'h7
`define IFS_CNT_ACK        4'h8

// Slave address byte fields.
`define IFS_TYPE_MSB       7
`define IFS_TYPE_LSB       4
`define IFS_SEL_MSB        3
`define IFS_SEL_LSB        1
`define IFS_RW_BIT         0

// High-speed master code prefix, bits 7..3 of the byte.
`define IFS_HS_MSB         7
`define IFS_HS_LSB         3
`define IFS_HS_PREFIX      5'h01

// Upper word-address byte keeps only its low five bits.
`define IFS_HI_MSB         4

`endif

// ### logic/ifs_pkg.sv
// Types shared by the two-wire memory slave.
`default_nettype none
package ifs_pkg;

    // Protocol phase of the link-side engine.
    typedef enum logic [2:0] {
        IFS_IDLE    = 3'b000,
        IFS_DEVSEL  = 3'b001,
        IFS_ADDR_HI = 3'b010,
        IFS_ADDR_LO = 3'b011,
        IFS_WRITE   = 3'b100,
        IFS_READ    = 3'b101
    } ifs_state_type;

    typedef logic [2:0]  ifs_sel_type;
    typedef logic [7:0]  ifs_byte_type;
    typedef logic [12:0] ifs_addr_type;

endpackage
`default_nettype wire

// ### logic/ifs_slave.sv
// Two-wire serial slave front end with an 8192 x 8 memory array.
`timescale 1ns/10ps
`default_nettype none
`include "ifs_regs.svh"

// Summary of operation
// - Sample on clock rise, drive after fall.
// - Data falling with clock high is start.
// - Data rising with clock high is stop.
// - Eight-bit bytes, each followed by acknowledge.
// - Transmitter releases data after eighth bit.
// - Receiver holds data low on ninth clock.
// - Acknowledge a matching slave address byte.
// - Upper four address bits match device type.
// - Next three bits match strap pins.
// - Lowest address bit selects read or write.
// - Acknowledge every word-address and data byte written.
// - Multi-byte writes advance address and wrap.
// - Writes past array size overwrite earliest bytes.
// - Write-protect high blocks all writes.
// - Random read: address write, restart, read.
// - Master acknowledge continues with next byte.
// - Master no-acknowledge releases and ends read.
// - Sequential reads advance address and wrap.
// - Current read returns last address plus one.
// - Address register undefined after power-up; here reset loads it with zero.
// - High-speed command holds until next stop.
// - Array holds 8192 eight-bit words.
module ifs_slave #(
    // Device-type code; this value is arbitrary.
    parameter logic [3:0] DEV_TYPE_CODE = 4'h5
) (
    input  wire logic                  clk,
    input  wire logic                  clk_en,
    input  wire logic                  nrst,
    input  wire logic                  scl,
    input  wire logic                  sda_in,
    output var  logic                  sda_out,
    output var  logic                  sda_oe,
    input  wire ifs_pkg::ifs_sel_type  chip_select_strap_pins,
    input  wire logic                  write_protect,
    output var  logic                  hs_mode
);
    import ifs_pkg::*;

    // Link-side state, clocked by the serial clock; the start and stop toggles by the data line.
    logic          scl_rst_ff1;
    logic          scl_rst_ff2;
    logic [2:0]    strap_ff1;
    logic [2:0]    strap_ff2;
    logic          wp_ff1;
    logic          wp_ff2;
    logic          start_tog;
    logic          stop_tog;
    logic          start_seen;
    logic          stop_seen;
    ifs_state_type state;
    ifs_state_type after_ack;
    logic [3:0]    bit_cnt;
    ifs_byte_type  rx_shift;
    ifs_byte_type  tx_shift;
    logic [4:0]    addr_hi;
    ifs_addr_type  cur_addr;
    logic          drive_req;
    logic          hs_tog;
    logic          req_tog;
    logic          req_we;
    ifs_addr_type  req_wa;
    ifs_byte_type  req_wd;
    ifs_addr_type  req_ra;

    // System-side state, clocked by clk.
    logic          rst_ff1;
    logic          rst_ff2;
    logic          req_s1;
    logic          req_s2;
    logic          req_s3;
    logic          hs_s1;
    logic          hs_s2;
    logic          hs_s3;
    logic          stop_s1;
    logic          stop_s2;
    logic          stop_s3;
    ifs_byte_type  rd_data;
    ifs_byte_type  mem [`IFS_MEM_WORDS];

    // Combinational view of the byte just completed on this rising edge.
    ifs_byte_type  rx_byte;
    logic          addr_match;
    logic          hs_code;
    ifs_addr_type  next_addr;

    assign rx_byte   = {rx_shift[6:0], sda_in};
    assign next_addr = cur_addr + `IFS_ADDR_STEP;
    assign hs_code   = rx_byte[`IFS_HS_MSB:`IFS_HS_LSB] == `IFS_HS_PREFIX;
    assign addr_match =
        (rx_byte[`IFS_TYPE_MSB:`IFS_TYPE_LSB] == DEV_TYPE_CODE) &&
        (rx_byte[`IFS_SEL_MSB:`IFS_SEL_LSB] == strap_ff2);

    // Link-side reset: asserted at once, released on the serial clock so
    // the engine never leaves reset in the middle of a clock edge.
    always_ff @(posedge scl or negedge nrst) begin
        if (!nrst) begin
            scl_rst_ff1 <= 1'b0;
            scl_rst_ff2 <= 1'b0;
        end else begin
            scl_rst_ff1 <= 1'b1;
            scl_rst_ff2 <= scl_rst_ff1;
        end
    end

    // Strap pins and write protect pass two flops before use.
    always_ff @(posedge scl or negedge scl_rst_ff2) begin
        if (!scl_rst_ff2) begin
            strap_ff1 <= 3'h0;
            strap_ff2 <= 3'h0;
            wp_ff1    <= 1'b0;
            wp_ff2    <= 1'b0;
        end else begin
            strap_ff1 <= chip_select_strap_pins;
            strap_ff2 <= strap_ff1;
            wp_ff1    <= write_protect;
            wp_ff2    <= wp_ff1;
        end
    end

    // Start: data falls while the clock is high. The clock stands still
    // between frames, so the event is kept as a toggle on the data edge.
    // There is no spike filter on the pins, so a data glitch while the
    // clock is high reads as a start or a stop.
    always_ff @(negedge sda_in or negedge nrst) begin
        if (!nrst) begin
            start_tog <= 1'b0;
        end else if (scl) begin
            start_tog <= ~start_tog;
        end
    end

    // Stop: data rises while the clock is high.
    always_ff @(negedge nrst or posedge sda_in) begin
        if (!nrst) begin
            stop_tog <= 1'b0;
        end else if (scl) begin
            stop_tog <= ~stop_tog;
        end
    end

    // Protocol engine. The start and stop toggles are read directly: the
    // bus start hold and stop setup times leave them settled long before
    // the next rising clock edge, which a synchroniser would only delay.
    always_ff @(posedge scl or negedge scl_rst_ff2) begin
        if (!scl_rst_ff2) begin
            start_seen <= 1'b0;
            stop_seen  <= 1'b0;
            state      <= IFS_IDLE;
            after_ack  <= IFS_IDLE;
            bit_cnt    <= `IFS_CNT_RST;
            rx_shift   <= `IFS_BYTE_RST;
            tx_shift   <= `IFS_BYTE_RST;
            addr_hi    <= `IFS_HI_RST;
            cur_addr   <= `IFS_ADDR_RST;
            drive_req  <= 1'b0;
            hs_tog     <= 1'b0;
            req_tog    <= 1'b0;
            req_we     <= 1'b0;
            req_wa     <= `IFS_ADDR_RST;
            req_wd     <= `IFS_BYTE_RST;
            req_ra     <= `IFS_ADDR_RST;
        end else if (start_tog != start_seen) begin
            // First bit of the slave address rides on this edge.
            start_seen <= start_tog;
            stop_seen  <= stop_tog;
            state      <= IFS_DEVSEL;
            bit_cnt    <= `IFS_CNT_FIRST;
            rx_shift   <= {7'h00, sda_in};
            drive_req  <= 1'b0;
        end else if (stop_tog != stop_seen) begin
            // A stop ends any command; ignore bits until a new start.
            stop_seen <= stop_tog;
            state     <= IFS_IDLE;
            bit_cnt   <= `IFS_CNT_RST;
            drive_req <= 1'b0;
        end else if (state == IFS_IDLE) begin
            drive_req <= 1'b0;
        end else if (bit_cnt == `IFS_CNT_ACK) begin
            // Ninth clock: acknowledge slot ends here.
            bit_cnt <= `IFS_CNT_RST;
            if (state == IFS_READ && sda_in) begin
                // Master declined more data: release and wait for stop.
                state     <= IFS_IDLE;
                drive_req <= 1'b0;
            end else if (after_ack == IFS_READ) begin
                // Master acked, or address phase done: send next byte.
                state     <= IFS_READ;
                tx_shift  <= rd_data;
                drive_req <= ~rd_data[7];
            end else begin
                state     <= after_ack;
                drive_req <= 1'b0;
            end
        end else begin
            bit_cnt  <= bit_cnt + `IFS_CNT_STEP;
            rx_shift <= rx_byte;
            if (state == IFS_READ) begin
                tx_shift <= {tx_shift[6:0], 1'b0};
                if (bit_cnt == `IFS_CNT_LAST_BIT) begin
                    // Release for the master's acknowledge; prefetch the
                    // next word now so it is ready a full clock later.
                    drive_req <= 1'b0;
                    after_ack <= IFS_READ;
                    cur_addr  <= next_addr;
                    req_we    <= 1'b0;
                    req_ra    <= next_addr;
                    req_tog   <= ~req_tog;
                end else begin
                    drive_req <= ~tx_shift[6];
                end
            end else if (bit_cnt != `IFS_CNT_LAST_BIT) begin
                drive_req <= 1'b0;
            end else begin
                // Eighth bit of a received byte.
                unique case (state)
                    IFS_DEVSEL: begin
                        if (hs_code) begin
                            drive_req <= 1'b0;
                            after_ack <= IFS_IDLE;
                            hs_tog    <= ~hs_tog;
                        end else if (addr_match) begin
                            drive_req <= 1'b1;
                            if (rx_byte[`IFS_RW_BIT]) begin
                                after_ack <= IFS_READ;
                            end else begin
                                after_ack <= IFS_ADDR_HI;
                            end
                        end else begin
                            drive_req <= 1'b0;
                            after_ack <= IFS_IDLE;
                        end
                    end
                    IFS_ADDR_HI: begin
                        addr_hi   <= rx_byte[`IFS_HI_MSB:0];
                        drive_req <= 1'b1;
                        after_ack <= IFS_ADDR_LO;
                    end
                    IFS_ADDR_LO: begin
                        cur_addr  <= {addr_hi, rx_byte};
                        req_we    <= 1'b0;
                        req_ra    <= {addr_hi, rx_byte};
                        req_tog   <= ~req_tog;
                        drive_req <= 1'b1;
                        after_ack <= IFS_WRITE;
                    end
                    IFS_WRITE: begin
                        // Protected bytes are still acknowledged; only
                        // the store is suppressed.
                        req_we    <= ~wp_ff2;
                        req_wa    <= cur_addr;
                        req_wd    <= rx_byte;
                        req_ra    <= next_addr;
                        req_tog   <= ~req_tog;
                        cur_addr  <= next_addr;
                        drive_req <= 1'b1;
                        after_ack <= IFS_WRITE;
                    end
                    default: begin
                        drive_req <= 1'b0;
                        after_ack <= IFS_IDLE;
                    end
                endcase
            end
        end
    end

    // Data pin: only ever pulled low, changed after the falling edge.
    // The driver is open drain: sda_out stays low and the enable alone
    // decides whether the line is pulled.
    always_ff @(negedge scl or negedge scl_rst_ff2) begin
        if (!scl_rst_ff2) begin
            sda_oe  <= 1'b0;
            sda_out <= 1'b0;
        end else begin
            sda_oe  <= drive_req;
            sda_out <= 1'b0;
        end
    end

    // System reset: asserted at once, released through two flops.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_ff1 <= 1'b0;
            rst_ff2 <= 1'b0;
        end else begin
            rst_ff1 <= 1'b1;
            rst_ff2 <= rst_ff1;
        end
    end

    // Event toggles from the link side cross through two flops; the
    // third flop only serves the edge compare. The enable freezes only
    // this side: the serial side keeps pace with the master, which
    // cannot be paused in mid-frame, and a toggle that lands while
    // frozen is still taken once the enable returns.
    always_ff @(posedge clk or negedge rst_ff2) begin
        if (!rst_ff2) begin
            req_s1  <= 1'b0;
            req_s2  <= 1'b0;
            req_s3  <= 1'b0;
            hs_s1   <= 1'b0;
            hs_s2   <= 1'b0;
            hs_s3   <= 1'b0;
            stop_s1 <= 1'b0;
            stop_s2 <= 1'b0;
            stop_s3 <= 1'b0;
        end else if (clk_en) begin
            req_s1  <= req_tog;
            req_s2  <= req_s1;
            req_s3  <= req_s2;
            hs_s1   <= hs_tog;
            hs_s2   <= hs_s1;
            hs_s3   <= hs_s2;
            stop_s1 <= stop_tog;
            stop_s2 <= stop_s1;
            stop_s3 <= stop_s2;
        end
    end

    // High-speed flag: set by the master code, cleared by a stop. A stop
    // seen in the same cycle wins, since it follows the code on the bus.
    always_ff @(posedge clk or negedge rst_ff2) begin
        if (!rst_ff2) begin
            hs_mode <= 1'b0;
        end else if (clk_en) begin
            if (stop_s2 != stop_s3) begin
                hs_mode <= 1'b0;
            end else if (hs_s2 != hs_s3) begin
                hs_mode <= 1'b1;
            end
        end
    end

    // Memory array. The request fields are held for a whole byte slot,
    // so they are stable when the synchronised toggle arrives. The array
    // has no reset: its contents are kept like those of a nonvolatile
    // store, and clearing every word would need a long sweep.
    always_ff @(posedge clk) begin
        if (clk_en && (req_s2 != req_s3) && req_we) begin
            mem[req_wa] <= req_wd;
        end
    end

    // Prefetch of the next word to send; forwards a byte written to the
    // same address in the same request. The serial side loads this word
    // without a synchroniser: it settles within a few system clocks,
    // long before the ninth serial clock edge that takes it.
    always_ff @(posedge clk or negedge rst_ff2) begin
        if (!rst_ff2) begin
            rd_data <= `IFS_BYTE_RST;
        end else if (clk_en && (req_s2 != req_s3)) begin
            if (req_we && req_wa == req_ra) begin
                rd_data <= req_wd;
            end else begin
                rd_data <= mem[req_ra];
            end
        end
    end

endmodule
`default_nettype wire

// ### verif/ifs_slave_props.sv
// Checker for the two-wire memory slave, bound to its top module.
`timescale 1ns/10ps
`default_nettype none
module ifs_slave_props #(
    parameter logic [3:0] DEV_TYPE_CODE = 4'h5
) (
    input wire logic                 clk,
    input wire logic                 clk_en,
    input wire logic                 nrst,
    input wire logic                 scl,
    input wire logic                 sda_in,
    input wire logic                 sda_out,
    input wire logic                 sda_oe,
    input wire ifs_pkg::ifs_sel_type chip_select_strap_pins,
    input wire logic                 write_protect,
    input wire logic                 hs_mode
);
    import ifs_pkg::*;
    logic       scl_q;
    logic       sda_q;
    logic       first;
    logic       sel;
    logic       rd;
    logic       match;
    logic [3:0] cnt;
    logic [7:0] shift;
    assign match = shift[7:4] == DEV_TYPE_CODE
                   && shift[3:1] == chip_select_strap_pins;
    // Frame position from wire levels; the fast clock sees every edge.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            first <= 1'b0;
            sel   <= 1'b0;
            rd    <= 1'b0;
            cnt   <= 4'h0;
            shift <= 8'h00;
        end else begin
            scl_q <= scl;
            sda_q <= sda_in;
            if (scl && scl_q && sda_q && !sda_in) begin
                cnt   <= 4'h0;
                first <= 1'b1;
                sel   <= 1'b0;
            end else if (scl && scl_q && !sda_q && sda_in) begin
                first <= 1'b0;
                sel   <= 1'b0;
            end else if (scl && !scl_q) begin
                cnt   <= (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
                shift <= {shift[6:0], sda_in};
                if (cnt == 4'h8) begin
                    first <= 1'b0;
                end
                if (cnt == 4'h8 && first) begin
                    sel <= match;
                    rd  <= shift[0];
                end else if (cnt == 4'h8 && rd && sda_in) begin
                    sel <= 1'b0;
                end
            end
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    sequence s_ack_slot;
        cnt == 4'h8 && !scl;
    endsequence
    sequence s_stop;
        scl && scl_q && !sda_q && sda_in;
    endsequence
    property p_addr_ack;
        first ##0 s_ack_slot |-> sda_oe == match;
    endproperty
    a_addr_ack: assert property (p_addr_ack)
        else $error("address acknowledge wrong");
    property p_addr_quiet;
        first && cnt < 4'h8 |-> !sda_oe;
    endproperty
    a_addr_quiet: assert property (p_addr_quiet)
        else $error("data line driven during address");
    property p_wr_ack;
        (!first && sel && !rd) ##0 s_ack_slot |-> sda_oe;
    endproperty
    a_wr_ack: assert property (p_wr_ack)
        else $error("written byte not acknowledged");
    property p_wr_quiet;
        !first && sel && !rd && cnt > 4'h0 && cnt < 4'h8 |-> !sda_oe;
    endproperty
    a_wr_quiet: assert property (p_wr_quiet)
        else $error("data line driven while receiving");
    property p_rd_rel;
        (!first && sel && rd) ##0 s_ack_slot |-> !sda_oe;
    endproperty
    a_rd_rel: assert property (p_rd_rel)
        else $error("line held in master acknowledge slot");
    property p_idle_quiet;
        !first && !sel |-> !sda_oe;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet)
        else $error("data line driven while deselected");
    property p_hs_stop;
        s_stop |-> ##[1:6] !hs_mode;
    endproperty
    a_hs_stop: assert property (p_hs_stop)
        else $error("speed mode kept after stop");
    property p_drive_low;
        $changed(sda_oe) |-> !scl;
    endproperty
    a_drive_low: assert property (p_drive_low)
        else $error("data output changed while clock high");
    property p_open_drain;
        !sda_out;
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("data output not low");
endmodule
bind ifs_slave ifs_slave_props #(.DEV_TYPE_CODE(DEV_TYPE_CODE)) i_props (
    .clk                    (clk),
    .clk_en                 (clk_en),
    .nrst                   (nrst),
    .scl                    (scl),
    .sda_in                 (sda_in),
    .sda_out                (sda_out),
    .sda_oe                 (sda_oe),
    .chip_select_strap_pins (chip_select_strap_pins),
    .write_protect          (write_protect),
    .hs_mode                (hs_mode)
);
`default_nettype wire

// ### verif/ifs_master_model.sv
// Bus master model driving the serial clock and pulling the data line.
`timescale 1ns/10ps
`default_nettype none
module ifs_master_model (
    output var  logic scl,
    output var  logic sda_pull,
    input  wire logic sda
);
    localparam real Q = 31.25;
    // The clock stands high between frames; data is only ever pulled low.
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    // Two idle clocks let the link side leave reset before a frame.
    task automatic idle2();
        repeat (2) begin
            #(2*Q) scl = 1'b0;
            #(2*Q) scl = 1'b1;
        end
    endtask
    task automatic start();
        sda_pull = 1'b0;
        #Q scl = 1'b1;
        #Q sda_pull = 1'b1;
        #Q scl = 1'b0;
        #Q;
    endtask
    task automatic stop();
        sda_pull = 1'b1;
        #Q scl = 1'b1;
        #Q sda_pull = 1'b0;
        #(2*Q);
    endtask
    task automatic send(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            sda_pull = ~b[i];
            #Q scl = 1'b1;
            #(2*Q) scl = 1'b0;
            #Q;
        end
        sda_pull = 1'b0;
        #Q scl = 1'b1;
        ack = ~sda;
        #(2*Q) scl = 1'b0;
        #Q;
    endtask
    task automatic recv(input logic nack, output logic [7:0] b);
        sda_pull = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            #Q scl = 1'b1;
            b[i] = sda;
            #(2*Q) scl = 1'b0;
            #Q;
        end
        sda_pull = ~nack;
        #Q scl = 1'b1;
        #(2*Q) scl = 1'b0;
        // The acknowledge stands a quarter bit past the fall; the next
        // recv or stop then sets the line itself, once.
        #Q;
    endtask
endmodule
`default_nettype wire

// ### verif/test_i2c_fram_slave_interface.sv
// Testbench for the two-wire memory slave against a bus master model.
`timescale 1ns/10ps
`default_nettype none
module test_i2c_fram_slave_interface;
    import ifs_pkg::*;
    // Device-type code; the value is arbitrary.
    localparam logic [3:0] TYPE = 4'h6;
    logic        clk = 1'b0;
    logic        clk_en;
    logic        nrst;
    logic        scl;
    logic        sda_pull;
    logic        sda;
    logic        sda_out;
    logic        sda_oe;
    logic        wp;
    logic        hs_mode;
    logic        ack;
    logic [7:0]  b;
    logic [7:0]  lo;
    logic [7:0]  mem [0:8191];
    logic [12:0] ptr;
    ifs_sel_type pins;
    int          seed;
    int          n;
    int          num_errors = 0;
    int          checked = 0;
    always #2 clk = ~clk;
    // The wire has a pull-up, so it is low only while somebody pulls it.
    assign sda = !(sda_pull || (sda_oe && !sda_out));
    ifs_slave #(.DEV_TYPE_CODE(TYPE)) i_ifs_slave (
        .clk                    (clk),
        .clk_en                 (clk_en),
        .nrst                   (nrst),
        .scl                    (scl),
        .sda_in                 (sda),
        .sda_out                (sda_out),
        .sda_oe                 (sda_oe),
        .chip_select_strap_pins (pins),
        .write_protect          (wp),
        .hs_mode                (hs_mode)
    );
    ifs_master_model i_ifs_master_model (
        .scl      (scl),
        .sda_pull (sda_pull),
        .sda      (sda)
    );
    function automatic logic acks(input logic [7:0] a);
        return a[7:4] == TYPE && a[3:1] == pins;
    endfunction
    function automatic logic [12:0] addr_of(input logic [7:0] h, l);
        return {h[4:0], l};
    endfunction
    task automatic check_bit(input string what, input logic e, input logic g);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected %s expected %b seen %b", what, e, g);
        end
    endtask
    task automatic check_byte(input string what, input logic [7:0] e,
                              input logic [7:0] g);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", what, e, g);
        end
    endtask
    // Start, write-direction address and both word-address bytes.
    task automatic open_at(input logic [7:0] h, input logic [7:0] l);
        logic [7:0] hdr [3];
        logic       a;
        hdr = '{{TYPE, pins, 1'b0}, h, l};
        i_ifs_master_model.start();
        foreach (hdr[k]) begin
            i_ifs_master_model.send(hdr[k], a);
            check_bit("header ack", 1'b1, a);
        end
        ptr = addr_of(h, l);
    endtask
    task automatic wr(input logic [7:0] h, input logic [7:0] l, input int k);
        logic [7:0] d;
        logic       a;
        open_at(h, l);
        for (int i = 0; i < k; i++) begin
            d = 8'($random(seed));
            i_ifs_master_model.send(d, a);
            check_bit("data ack", 1'b1, a);
            if (!wp) mem[ptr] = d;
            ptr = ptr + 13'h0001;
        end
        i_ifs_master_model.stop();
    endtask
    // Read k bytes from the current address, refusing the last one.
    task automatic rd(input int k);
        logic [7:0] d;
        logic       a;
        i_ifs_master_model.start();
        i_ifs_master_model.send({TYPE, pins, 1'b1}, a);
        check_bit("read address ack", 1'b1, a);
        for (int i = 0; i < k; i++) begin
            i_ifs_master_model.recv(i == k - 1, d);
            check_byte("read data", mem[ptr], d);
            ptr = ptr + 13'h0001;
        end
        i_ifs_master_model.stop();
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Main sequence; expectations come from the bench's own memory copy.
    initial begin
        seed = 94154;
        nrst = 1'b0;
        clk_en = 1'b1;
        wp = 1'b0;
        pins = 3'($random(seed));
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        repeat (2) @(posedge clk);
        i_ifs_master_model.idle2();
        wr(8'hFF, 8'hFE, 5);
        open_at(8'h1F, 8'hFE);
        rd(4);
        rd(1);
        @(posedge clk) wp <= 1'b1;
        wr(8'h1F, 8'hFE, 2);
        @(posedge clk) wp <= 1'b0;
        open_at(8'h1F, 8'hFE);
        rd(2);
        // Every select value, a foreign type code and the speed code.
        for (int s = 0; s < 24; s++) begin
            if (s < 8) b = {TYPE, 3'(s), 1'b0};
            else if (s < 16) b = {~TYPE, 3'(s), 1'b0};
            else b = {5'h01, 3'(s)};
            i_ifs_master_model.start();
            i_ifs_master_model.send(b, ack);
            check_bit("select ack", acks(b), ack);
            if (s >= 16) check_bit("speed mode", 1'b1, hs_mode);
            i_ifs_master_model.stop();
            repeat (8) @(posedge clk);
            check_bit("speed mode", 1'b0, hs_mode);
        end
        // A frozen system side holds the speed flag until enabled again.
        i_ifs_master_model.start();
        @(posedge clk) clk_en <= 1'b0;
        i_ifs_master_model.send(8'h08, ack);
        check_bit("frozen speed mode", 1'b0, hs_mode);
        @(posedge clk) clk_en <= 1'b1;
        repeat (8) @(posedge clk);
        check_bit("released speed mode", 1'b1, hs_mode);
        i_ifs_master_model.stop();
        repeat (8) @(posedge clk);
        check_bit("speed mode", 1'b0, hs_mode);
        repeat (4) begin
            b = 8'($random(seed));
            lo = 8'($random(seed));
            n = 1 + ($random(seed) & 3);
            wr(b, lo, n);
            open_at(b, lo);
            rd(n);
        end
        complete_run();
    end
    // Cuts a hang short; running out counts as a mismatch.
    initial begin
        #400000;
        num_errors++;
        complete_run();
    end
endmodule
`default_nettype wire
